// ===== inc/cp_ctrl_pkg.sv
package cp_ctrl_pkg;

  // Bus and channel widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_OUT = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_OUT_ENABLE = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h02;

  // Software control bits, bit 4 down to bit 0 of the control register
  typedef struct packed {
    logic pump_force_enable;
    logic pump_auto_enable;
    logic upshift_debounce_select;
    logic ratio_manual_select;
    logic pump_ratio;
  } ctrl_type;

  localparam int unsigned CTRL_W = $bits(ctrl_type);

  // Both enables stay off so an unfitted pump is never started
  localparam ctrl_type CTRL_RESET = '{
    pump_force_enable: 1'b0,
    pump_auto_enable: 1'b0,
    upshift_debounce_select: 1'b0,
    ratio_manual_select: 1'b0,
    pump_ratio: 1'b0
  };
  localparam logic [NUM_OUT-1:0] OUT_ENABLE_RESET = 4'h0;

  // Drive towards the analog pump
  typedef struct packed {
    logic pump_on;
    logic ratio_double;
    logic soft_limit;
  } pump_drive_type;

  localparam int unsigned DRIVE_W = $bits(pump_drive_type);
  localparam pump_drive_type DRIVE_RESET = '{pump_on: 1'b0, ratio_double: 1'b0, soft_limit: 1'b0};

  // Ratio encoding
  localparam logic RATIO_BYPASS = 1'b0;
  localparam logic RATIO_DOUBLE = 1'b1;

  // Automatic ratio selection states, Gray along idle, bypass, double
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_BYPASS = 2'b01,
    ST_DOUBLE = 2'b11
  } auto_state_type;

  // Timing
  localparam int unsigned CLK_FREQ_MHZ = 100;
  localparam int unsigned DEB_LONG_MS = 32;
  localparam int unsigned DEB_SHORT_US = 200;
  localparam int unsigned SOFT_START_US = 20;
  localparam int unsigned DEB_LONG_CYCLES = DEB_LONG_MS * 1000 * CLK_FREQ_MHZ;
  localparam int unsigned DEB_SHORT_CYCLES = DEB_SHORT_US * CLK_FREQ_MHZ;
  localparam int unsigned SOFT_START_CYCLES = SOFT_START_US * CLK_FREQ_MHZ;
  localparam int unsigned DEB_CNT_W = 22;
  localparam int unsigned SOFT_CNT_W = 12;

endpackage

// ===== rtl/dropout_sync.sv
`timescale 1ns/10ps
module dropout_sync (
  input wire logic CLK_SYS, // System clock
  input wire logic RESET, // Asynchronous reset, active high
  input wire logic [cp_ctrl_pkg::NUM_OUT-1:0] ASYNC_IN, // Raw comparator flags
  output logic [cp_ctrl_pkg::NUM_OUT-1:0] SYNC_OUT // Synchronised flags
);
  import cp_ctrl_pkg::*;

  genvar i;
  generate
    for (i = 0; i < NUM_OUT; i++) begin : g_bit
      logic meta_q;
      logic stable_q;
      // First stage feeds only the second one
      always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q <= ASYNC_IN[i];
          stable_q <= meta_q;
        end
      end
      assign SYNC_OUT[i] = stable_q;
    end
  endgenerate
endmodule

// ===== rtl/charge_pump_mode_control.sv
`timescale 1ns/10ps
// How it works
// - The pump always runs in exactly one ratio, either bypass or doubling.
// - In automatic operation every pump start begins in bypass and moves up to doubling on its own when needed.
// - In manual operation the ratio written by software is applied with no automatic change.
// - Only enabled current outputs are watched, and a dropout on any of them requests an upshift.
// - The upshift happens only after the request has lasted 32 ms, or 200 us with the short debounce selected.
// - Automatic selection only moves up and never falls back to bypass while outputs stay on.
// - Switching all outputs off re-arms automatic selection so it starts again from bypass.
// - A running pattern switches the outputs off after each cycle, re-arming selection once per cycle.
// - A soft-start current limit is applied at pump start and at every ratio change.
// - The manual select bit picks automatic selection at 0 and software ratio at 1, automatic by default.
// - Reading the ratio field returns the ratio the pump actually runs in.
// - With the automatic enable alone the pump turns itself off once all outputs are off.
// - With the forced enable the pump keeps running after start even with all outputs off.
module charge_pump_mode_control #(
  parameter int unsigned DEB_LONG = cp_ctrl_pkg::DEB_LONG_CYCLES, // Long debounce, cycles
  parameter int unsigned DEB_SHORT = cp_ctrl_pkg::DEB_SHORT_CYCLES // Short debounce, cycles
) (
  input wire logic CLK_SYS, // System clock, 100 MHz
  input wire logic RESET, // Asynchronous reset, active high
  input wire logic [cp_ctrl_pkg::ADDR_W-1:0] ADDR, // Register address
  input wire logic [cp_ctrl_pkg::DATA_W-1:0] WDATA, // Write data
  input wire logic WR, // Write strobe
  input wire logic RD, // Read strobe
  output logic [cp_ctrl_pkg::DATA_W-1:0] RDATA, // Read data, cycle after RD
  input wire logic PATTERN_RUN, // Pattern generator active
  input wire logic PATTERN_CYCLE_END, // Pulse at end of each pattern cycle
  input wire logic [cp_ctrl_pkg::NUM_OUT-1:0] DROPOUT, // Output below dropout threshold
  output logic [cp_ctrl_pkg::NUM_OUT-1:0] LED_ENABLE, // Current output enables
  output cp_ctrl_pkg::pump_drive_type PUMP_DRIVE // Pump switch control
);
  import cp_ctrl_pkg::*;

  localparam logic [DEB_CNT_W-1:0] DEB_LONG_LAST = DEB_CNT_W'(DEB_LONG - 1);
  localparam logic [DEB_CNT_W-1:0] DEB_SHORT_LAST = DEB_CNT_W'(DEB_SHORT - 1);
  localparam logic [SOFT_CNT_W-1:0] SOFT_LAST = SOFT_CNT_W'(SOFT_START_CYCLES - 1);
  localparam logic [DEB_CNT_W-1:0] DEB_ONE = DEB_CNT_W'(1);
  localparam logic [SOFT_CNT_W-1:0] SOFT_ONE = SOFT_CNT_W'(1);

  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    addr_hit = (a == ofs);
  endfunction

  logic [NUM_OUT-1:0] drop_s;
  ctrl_type ctrl_q, ctrl_d;
  logic [NUM_OUT-1:0] out_en_q, out_en_d;
  logic [NUM_OUT-1:0] led_q, led_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  auto_state_type st_q, st_d;
  logic [DEB_CNT_W-1:0] deb_q, deb_d;
  logic [SOFT_CNT_W-1:0] soft_cnt_q, soft_cnt_d;
  pump_drive_type drv_q, drv_d;
  logic any_on;
  logic drop_req;
  logic deb_hit;
  logic soft_load;
  logic [DEB_CNT_W-1:0] deb_last;

  dropout_sync u_sync (
    .CLK_SYS(CLK_SYS),
    .RESET(RESET),
    .ASYNC_IN(DROPOUT),
    .SYNC_OUT(drop_s)
  );

  // Register file
  always_comb begin
    ctrl_d = ctrl_q;
    out_en_d = out_en_q;
    rdata_d = '0;
    if (WR && addr_hit(ADDR, OFS_CONTROL)) begin
      ctrl_d = ctrl_type'(WDATA[CTRL_W-1:0]);
    end
    if (WR && addr_hit(ADDR, OFS_OUT_ENABLE)) begin
      out_en_d = WDATA[NUM_OUT-1:0];
    end
    if (RD) begin
      if (addr_hit(ADDR, OFS_CONTROL)) begin
        // Ratio field shows the running ratio, not the written one
        rdata_d = DATA_W'({ctrl_q[CTRL_W-1:1], drv_q.ratio_double});
      end else if (addr_hit(ADDR, OFS_OUT_ENABLE)) begin
        rdata_d = DATA_W'(out_en_q);
      end else if (addr_hit(ADDR, OFS_STATUS)) begin
        rdata_d = DATA_W'({st_q, drv_q});
      end
    end
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      ctrl_q <= CTRL_RESET;
      out_en_q <= OUT_ENABLE_RESET;
      rdata_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      out_en_q <= out_en_d;
      rdata_q <= rdata_d;
    end
  end

  assign RDATA = rdata_q;

  // Outputs and automatic selection
  always_comb begin
    // One blanked cycle at each pattern cycle end clears the selection
    led_d = (PATTERN_RUN && PATTERN_CYCLE_END) ? '0 : out_en_q;
    any_on = |led_q;
    drv_d = drv_q;
    st_d = st_q;
    deb_d = '0;
    deb_hit = 1'b0;
    soft_cnt_d = soft_cnt_q;
    deb_last = ctrl_q.upshift_debounce_select ? DEB_SHORT_LAST : DEB_LONG_LAST;
    drop_req = ((drop_s & led_q) != '0) && (st_q == ST_BYPASS) && !ctrl_q.ratio_manual_select;

    if (!ctrl_q.pump_force_enable && !ctrl_q.pump_auto_enable) begin
      drv_d.pump_on = 1'b0;
    end else if (!drv_q.pump_on) begin
      drv_d.pump_on = any_on;
    end else if (ctrl_q.pump_force_enable) begin
      drv_d.pump_on = 1'b1;
    end else begin
      drv_d.pump_on = any_on;
    end

    if (drop_req) begin
      // Catches a count already past a newly shortened limit
      deb_hit = (deb_q >= deb_last);
      deb_d = deb_hit ? '0 : deb_q + DEB_ONE;
    end

    if (!any_on || !drv_q.pump_on || ctrl_q.ratio_manual_select) begin
      st_d = ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE: st_d = ST_BYPASS;
        ST_BYPASS: st_d = deb_hit ? ST_DOUBLE : ST_BYPASS;
        ST_DOUBLE: st_d = ST_DOUBLE;
        default: st_d = ST_IDLE;
      endcase
    end

    // Single bit: bypass or doubling, never both
    if (!drv_d.pump_on) begin
      drv_d.ratio_double = RATIO_BYPASS;
    end else if (ctrl_q.ratio_manual_select) begin
      drv_d.ratio_double = ctrl_q.pump_ratio;
    end else begin
      drv_d.ratio_double = (st_d == ST_DOUBLE) ? RATIO_DOUBLE : RATIO_BYPASS;
    end

    soft_load = drv_d.pump_on && (!drv_q.pump_on || (drv_d.ratio_double != drv_q.ratio_double));
    if (soft_load) begin
      soft_cnt_d = SOFT_LAST;
    end else if (soft_cnt_q != '0) begin
      soft_cnt_d = soft_cnt_q - SOFT_ONE;
    end
    drv_d.soft_limit = soft_load || (soft_cnt_q != '0);
  end

  always_ff @(posedge CLK_SYS or posedge RESET) begin
    if (RESET) begin
      led_q <= OUT_ENABLE_RESET;
      drv_q <= DRIVE_RESET;
      st_q <= ST_IDLE;
      deb_q <= '0;
      soft_cnt_q <= '0;
    end else begin
      led_q <= led_d;
      drv_q <= drv_d;
      st_q <= st_d;
      deb_q <= deb_d;
      soft_cnt_q <= soft_cnt_d;
    end
  end

  assign LED_ENABLE = led_q;
  assign PUMP_DRIVE = drv_q;

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RESET);

  a_ratio_off_bypass: assert property (!drv_q.pump_on |-> drv_q.ratio_double == RATIO_BYPASS)
    else $error("ratio not bypass while pump off");
  a_auto_start_bypass: assert property ($rose(drv_q.pump_on) && !$past(ctrl_q.ratio_manual_select)
    |-> drv_q.ratio_double == RATIO_BYPASS)
    else $error("automatic start not in bypass");
  a_manual_ratio: assert property (ctrl_q.ratio_manual_select && drv_d.pump_on
    |=> drv_q.ratio_double == $past(ctrl_q.pump_ratio))
    else $error("manual ratio not applied");
  a_monitor_enabled: assert property (deb_q != '0 |-> $past((drop_s & led_q) != '0))
    else $error("debounce ran without enabled dropout");
  a_upshift_debounce: assert property ($rose(st_q == ST_DOUBLE) |-> $past(deb_hit))
    else $error("upshift before debounce elapsed");
  a_no_downshift: assert property (st_q == ST_DOUBLE && any_on && drv_q.pump_on
    && !ctrl_q.ratio_manual_select |=> st_q == ST_DOUBLE)
    else $error("automatic selection moved down");
  a_rearm_all_off: assert property (!any_on |=> st_q == ST_IDLE ##1 st_q != ST_DOUBLE)
    else $error("selection not re-armed");
  a_pattern_blank: assert property (PATTERN_RUN && PATTERN_CYCLE_END |=> led_q == '0)
    else $error("outputs not blanked at pattern cycle end");
  a_soft_start: assert property ($rose(drv_q.pump_on) || (drv_q.pump_on && $changed(drv_q.ratio_double))
    |-> drv_q.soft_limit [*2])
    else $error("soft start missing");
  a_auto_off: assert property (ctrl_q.pump_auto_enable && !ctrl_q.pump_force_enable && !any_on
    |=> !drv_q.pump_on)
    else $error("automatic pump did not turn off");
  a_force_hold: assert property (ctrl_q.pump_force_enable && drv_q.pump_on |=> drv_q.pump_on)
    else $error("forced pump stopped");
  a_debounce_restart: assert property ((drop_s & led_q) == '0 |=> deb_q == '0)
    else $error("debounce count not restarted");
  a_ratio_readback: assert property (RD && addr_hit(ADDR, OFS_CONTROL)
    |=> RDATA[0] == $past(drv_q.ratio_double))
    else $error("ratio readback wrong");

  // Finer checks on outputs, selection, pump enable and the debounce count
  a_led_follow: assert property (!(PATTERN_RUN && PATTERN_CYCLE_END)
    |=> led_q == $past(out_en_q))
    else $error("outputs do not follow enables");
  a_blank_rearm: assert property (PATTERN_RUN && PATTERN_CYCLE_END
    |=> ##1 st_q == ST_IDLE)
    else $error("pattern cycle end did not re-arm");
  a_manual_idle: assert property (ctrl_q.ratio_manual_select
    |=> st_q == ST_IDLE)
    else $error("automatic selection active in manual mode");
  a_manual_no_count: assert property (ctrl_q.ratio_manual_select
    |=> deb_q == '0)
    else $error("debounce ran in manual mode");
  a_auto_ratio_state: assert property (drv_q.pump_on && !$past(ctrl_q.ratio_manual_select)
    |-> drv_q.ratio_double == (st_q == ST_DOUBLE))
    else $error("automatic ratio differs from selection state");
  a_bypass_first: assert property ($rose(drv_q.pump_on)
    |-> st_q == ST_IDLE)
    else $error("selection not fresh at pump start");
  a_idle_no_jump: assert property (st_q == ST_IDLE
    |=> st_q != ST_DOUBLE)
    else $error("selection skipped bypass");
  a_pump_off_idle: assert property (!drv_q.pump_on
    |=> st_q == ST_IDLE)
    else $error("selection held with pump off");
  a_bypass_waits: assert property (st_q == ST_BYPASS && !deb_hit
    |=> st_q != ST_DOUBLE)
    else $error("upshift without debounce hit");
  a_count_step: assert property (drop_req && !deb_hit
    |=> deb_q == $past(deb_q) + DEB_ONE)
    else $error("debounce count skipped");
  a_count_clear: assert property (deb_hit
    |=> deb_q == '0)
    else $error("debounce count not cleared after upshift");
  a_disabled_ignored: assert property ((drop_s & led_q) == '0
    |-> !drop_req)
    else $error("dropout requested without enabled flag");
  a_only_bypass_counts: assert property (st_q != ST_BYPASS
    |=> deb_q == '0)
    else $error("debounce ran outside bypass");
  a_force_start: assert property (ctrl_q.pump_force_enable && any_on
    |=> drv_q.pump_on)
    else $error("forced pump did not run");
  a_auto_start: assert property (ctrl_q.pump_auto_enable && any_on
    |=> drv_q.pump_on)
    else $error("automatic pump did not start");
  a_off_stays_off: assert property (!drv_q.pump_on && !any_on
    |=> !drv_q.pump_on)
    else $error("pump started with all outputs off");
  a_both_disabled: assert property (!ctrl_q.pump_force_enable && !ctrl_q.pump_auto_enable
    |=> !drv_q.pump_on)
    else $error("pump ran with both enables clear");

  // Soft start is a counted window, so both of its edges are pinned
  a_soft_window: assert property (soft_cnt_q != '0
    |-> drv_q.soft_limit)
    else $error("limit off inside soft start window");
  a_soft_reload: assert property (soft_load
    |=> soft_cnt_q == SOFT_LAST)
    else $error("soft start window not reloaded");
  a_soft_step: assert property (!soft_load && soft_cnt_q != '0
    |=> soft_cnt_q == $past(soft_cnt_q) - SOFT_ONE)
    else $error("soft start count skipped");
  a_soft_release: assert property (!soft_load && soft_cnt_q == '0
    |=> !drv_q.soft_limit)
    else $error("limit held after soft start window");

  a_ctrl_write: assert property (WR && addr_hit(ADDR, OFS_CONTROL)
    |=> ctrl_q == ctrl_type'($past(WDATA[CTRL_W-1:0])))
    else $error("control write lost");
  a_ctrl_readback: assert property (RD && addr_hit(ADDR, OFS_CONTROL)
    |=> RDATA[CTRL_W-1:1] == $past(ctrl_q[CTRL_W-1:1]))
    else $error("control readback wrong");
  a_enable_write: assert property (WR && addr_hit(ADDR, OFS_OUT_ENABLE)
    |=> out_en_q == $past(WDATA[NUM_OUT-1:0]))
    else $error("enable write lost");
  a_enable_readback: assert property (RD && addr_hit(ADDR, OFS_OUT_ENABLE)
    |=> RDATA == DATA_W'($past(out_en_q)))
    else $error("enable readback wrong");
  a_status_ratio: assert property (RD && addr_hit(ADDR, OFS_STATUS)
    |=> RDATA[1] == $past(drv_q.ratio_double))
    else $error("status ratio wrong");
  a_rdata_quiet: assert property (!RD
    |=> RDATA == '0)
    else $error("read data outside read cycle");

endmodule

// ===== tb/cp_analog_model.sv
`timescale 1ns/10ps
module cp_analog_model (
  input wire logic CLK_SYS, // System clock
  input wire logic [cp_ctrl_pkg::NUM_OUT-1:0] LOW_MASK, // Outputs short of headroom in bypass
  input cp_ctrl_pkg::pump_drive_type PUMP_DRIVE, // Pump switch control
  output logic [cp_ctrl_pkg::NUM_OUT-1:0] DROPOUT // Comparator flags
);
  import cp_ctrl_pkg::*;
  initial DROPOUT = '0;
  // Doubling restores headroom, so the flags fall once the ratio is up
  always @(posedge CLK_SYS) begin
    DROPOUT <= #1 LOW_MASK & {NUM_OUT{~PUMP_DRIVE.ratio_double}};
  end
endmodule

// ===== tb/charge_pump_mode_control_tb.sv
`timescale 1ns/10ps
module charge_pump_mode_control_tb;
  import cp_ctrl_pkg::*;
  // Short counts keep the run brief
  localparam int unsigned DL = 40;
  localparam int unsigned DS = 10;
  logic CLK_SYS = 1'b0;
  logic RESET = 1'b1;
  logic [ADDR_W-1:0] ADDR = '0;
  logic [DATA_W-1:0] WDATA = '0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic PATTERN_RUN = 1'b0;
  logic PATTERN_CYCLE_END = 1'b0;
  logic [NUM_OUT-1:0] low_mask = '0;
  logic [NUM_OUT-1:0] DROPOUT;
  logic [NUM_OUT-1:0] LED_ENABLE;
  logic [DATA_W-1:0] RDATA;
  pump_drive_type PUMP_DRIVE;
  logic [15:0] exp_q[$];
  logic [15:0] note;
  logic rd_seen = 1'b0;
  logic [31:0] rnd;
  int d;
  int err_count = 0;
  int n_compared = 0;
  int cycles = 0;

  charge_pump_mode_control #(.DEB_LONG(DL), .DEB_SHORT(DS)) dut (
    .CLK_SYS(CLK_SYS), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .PATTERN_RUN(PATTERN_RUN), .PATTERN_CYCLE_END(PATTERN_CYCLE_END), .DROPOUT(DROPOUT),
    .LED_ENABLE(LED_ENABLE), .PUMP_DRIVE(PUMP_DRIVE)
  );
  cp_analog_model partner (.CLK_SYS(CLK_SYS), .LOW_MASK(low_mask), .PUMP_DRIVE(PUMP_DRIVE), .DROPOUT(DROPOUT));

  initial begin
    forever #5 CLK_SYS = ~CLK_SYS;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] expd);
    n_compared++;
    if (seen !== expd) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, expd);
    end
  endtask

  task automatic final_report();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge CLK_SYS);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge CLK_SYS);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK_SYS);
    WR <= 1'b0;
  endtask

  // Mask hides bits whose moment the checks do not pin down
  task automatic rd(input logic [7:0] a, input logic [7:0] expd, input logic [7:0] mask = 8'hff);
    @(posedge CLK_SYS);
    exp_q.push_back({mask, expd});
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK_SYS);
    RD <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge CLK_SYS) begin
    rd_seen <= RD;
    if (rd_seen) begin
      note = exp_q.pop_front();
      check(RDATA & note[15:8], note[7:0]);
    end
  end

  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      final_report();
    end
  end

  initial begin
    rnd = $urandom(77);
    idle(8);
    RESET <= 1'b0;
    for (int a = 0; a < 4; a++) rd(a[7:0], 8'h00);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h00);
    repeat (6) begin
      rnd = $urandom;
      wr(OFS_OUT_ENABLE, rnd[7:0]);
      rd(OFS_OUT_ENABLE, rnd[7:0] & 8'h0f);
      rd(OFS_STATUS, 8'h00, 8'h04);
    end
    wr(OFS_OUT_ENABLE, 8'h00);
    for (int s = 0; s < 2; s++) begin
      d = (s == 1) ? DS : DL;
      wr(OFS_OUT_ENABLE, 8'h01);
      wr(OFS_CONTROL, (s == 1) ? 8'h0c : 8'h08);
      idle(4);
      rd(OFS_STATUS, 8'h0d);
      low_mask <= 4'h4;
      idle(d + 20);
      rd(OFS_STATUS, 8'h0c, 8'h1e);
      low_mask <= 4'h5;
      idle(d / 2);
      low_mask <= 4'h4;
      idle(3);
      low_mask <= 4'h5;
      idle(d - 1);
      rd(OFS_STATUS, 8'h0c, 8'h1e);
      idle(8);
      rd(OFS_STATUS, 8'h1f);
      rd(OFS_CONTROL, (s == 1) ? 8'h0d : 8'h09);
      low_mask <= 4'h0;
      idle(2100);
      rd(OFS_STATUS, 8'h1e);
      PATTERN_RUN <= 1'b1;
      @(posedge CLK_SYS);
      PATTERN_CYCLE_END <= 1'b1;
      @(posedge CLK_SYS);
      PATTERN_CYCLE_END <= 1'b0;
      PATTERN_RUN <= 1'b0;
      @(negedge CLK_SYS);
      check({4'h0, LED_ENABLE}, 8'h00);
      @(negedge CLK_SYS);
      check({5'h00, PUMP_DRIVE}, 8'h00);
      check({4'h0, LED_ENABLE}, 8'h01);
      idle(6);
      rd(OFS_STATUS, 8'h0c, 8'h1e);
      wr(OFS_OUT_ENABLE, 8'h00);
      idle(3);
      rd(OFS_STATUS, 8'h00, 8'h1e);
      wr(OFS_CONTROL, 8'h00);
    end
    wr(OFS_OUT_ENABLE, 8'h02);
    wr(OFS_CONTROL, 8'h10);
    idle(4);
    wr(OFS_OUT_ENABLE, 8'h00);
    idle(4);
    rd(OFS_STATUS, 8'h04, 8'h06);
    wr(OFS_CONTROL, 8'h13);
    idle(3);
    rd(OFS_STATUS, 8'h06, 8'h06);
    rd(OFS_CONTROL, 8'h13);
    low_mask <= 4'hf;
    wr(OFS_OUT_ENABLE, 8'h0f);
    wr(OFS_CONTROL, 8'h12);
    idle(DL + 20);
    rd(OFS_STATUS, 8'h04, 8'h1e);
    // Let the last read data reach the checker first
    idle(2);
    final_report();
  end
endmodule
